// ===== rtl/wwd_pkg.sv
package wwd_pkg;
    // Prescaler and counter geometry.
    localparam int PRESCALE_CYCLES = 16384;
    localparam int PRESCALE_W = 14;
    localparam int CTRL_W = 8;
    localparam int ACT_BIT = 7;
    localparam int TOP_BIT = 6;
    localparam int CNT_W = 7;
    localparam int STEP_W = 6;
    localparam int STEP_COUNT = 64;
    localparam logic [7:0] CTRL_RESET = 8'h7F;
    localparam logic [6:0] CNT_EXPIRE_FROM = 7'h40;
    localparam logic [6:0] CNT_EXPIRE_TO = 7'h3F;
    localparam logic [7:0] REFRESH_MAX = 8'hFF;
    localparam logic [7:0] REFRESH_MIN = 8'hC0;
    // Reset pulse timing.
    localparam int CLK_PERIOD_PS = 25000;
    localparam int PULSE_NS = 500;
    localparam int PULSE_CYCLES = (PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int PULSE_W = 6;
    // Resume delays after halt exit, in CPU clocks.
    localparam int RESUME_SHORT = 256;
    localparam int RESUME_LONG = 4096;
    localparam int RESUME_W = 13;
    typedef enum logic [1:0] {
        WWD_RUN,
        WWD_HALT_ONE,
        WWD_FROZEN,
        WWD_RESUME
    } wwd_mode_t;
endpackage : wwd_pkg

// ===== rtl/wwd_prescaler.sv
`timescale 1ns/1ps
`default_nettype none
module wwd_prescaler #(
    parameter int DIVIDE = wwd_pkg::PRESCALE_CYCLES
) (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic arst_n,
    // Control.
    input wire logic run,
    // Output.
    output logic tick
);
    logic [wwd_pkg::PRESCALE_W-1:0] count_q;
    logic [wwd_pkg::PRESCALE_W-1:0] count_d;
    logic tick_d;

    always_comb begin
        count_d = count_q;
        tick_d = 1'b0;
        if (run) begin
            if (count_q == wwd_pkg::PRESCALE_W'(DIVIDE - 1)) begin
                count_d = '0;
                tick_d = 1'b1;
            end else begin
                count_d = count_q + 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            count_q <= '0;
            tick <= 1'b0;
        end else begin
            count_q <= count_d;
            tick <= tick_d;
        end
    end
endmodule : wwd_prescaler
`default_nettype wire

// ===== rtl/wwd_watchdog.sv
// Functional notes
// - Counter decrements once per 16384 clocks from a prescaler that runs only in run and halt-one modes.
// - Lower six counter bits set the timeout in 64 steps.
// - Activated counter stepping 40h to 3Fh drives reset low about 500ns.
// - Counter runs down even when the watchdog is not activated.
// - Timeout varies by up to one prescaler period after a write.
// - Comes out of reset deactivated; activation sticks until reset.
// - Write with activation set and top bit clear resets at once.
// - Active, timebase interrupt off, halt-reset option set: halt resets.
// - Halt without option: one decrement, then frozen, no reset until wake.
// - External interrupt wake from halt resumes counting after 256/4096 clocks.
// - Reset out of halt deactivates, unless hardware watchdog option.
// - Timebase interrupt on: active-halt stops counter, restarts at once on wake.
// - Reset out of active-halt resumes counting after 256/4096 clocks.
// - Hardware watchdog option makes it always active, activation bit unused.
// - Control holds activation at bit 7, counter bits 6..0, reset 7Fh.
`timescale 1ns/1ps
`default_nettype none
module wwd_watchdog #(
    parameter int PRESCALE = wwd_pkg::PRESCALE_CYCLES,
    parameter int RESUME_SHORT = wwd_pkg::RESUME_SHORT,
    parameter int RESUME_LONG = wwd_pkg::RESUME_LONG
) (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic arst_n,
    // Control register write port, same clock domain.
    input wire logic ctrlWrite,
    input wire logic [7:0] ctrlWdata,
    // Mode and option inputs.
    input wire logic haltEnter,
    input wire logic extWake,
    input wire logic oscWake,
    input wire logic wokeFromReset,
    input wire logic timebaseInterruptEnable,
    input wire logic haltResetOption,
    input wire logic hardwareWatchdogOption,
    input wire logic longResumeDelay,
    // Status and reset pin.
    output logic [7:0] ctrlRdata,
    output logic counting,
    output logic resetPin_n,
    output logic resetPinOe_n
);
    logic activation_q;
    logic activation_d;
    logic [wwd_pkg::CNT_W-1:0] cnt_q;
    logic [wwd_pkg::CNT_W-1:0] cnt_d;
    wwd_pkg::wwd_mode_t mode_q;
    wwd_pkg::wwd_mode_t mode_d;
    logic [wwd_pkg::RESUME_W-1:0] resume_q;
    logic [wwd_pkg::RESUME_W-1:0] resume_d;
    logic [wwd_pkg::PULSE_W-1:0] pulse_q;
    logic [wwd_pkg::PULSE_W-1:0] pulse_d;
    logic strapDone_q;
    logic strapDone_d;
    logic [7:0] rdata_d;
    logic counting_d;
    logic tick;
    logic preRun;
    logic active;
    logic fire;
    logic decNow;

    assign active = activation_q | hardwareWatchdogOption;
    assign preRun = (mode_q == wwd_pkg::WWD_RUN) || (mode_q == wwd_pkg::WWD_HALT_ONE);
    wwd_prescaler #(
        .DIVIDE(PRESCALE)
    ) u_pre (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .run(preRun),
        .tick(tick)
    );

    always_comb begin
        activation_d = activation_q;
        cnt_d = cnt_q;
        mode_d = mode_q;
        resume_d = resume_q;
        strapDone_d = 1'b1;
        fire = 1'b0;
        decNow = 1'b0;
        case (mode_q)
            wwd_pkg::WWD_RUN: begin
                decNow = tick;
                if (haltEnter) begin
                    if (timebaseInterruptEnable) begin
                        mode_d = wwd_pkg::WWD_FROZEN;
                    end else if (active && haltResetOption) begin
                        fire = 1'b1;
                    end else begin
                        mode_d = wwd_pkg::WWD_HALT_ONE;
                    end
                end
            end
            wwd_pkg::WWD_HALT_ONE: begin
                decNow = tick;
                if (tick) begin
                    mode_d = wwd_pkg::WWD_FROZEN;
                end
            end
            wwd_pkg::WWD_FROZEN: begin
                if (timebaseInterruptEnable && (oscWake || extWake)) begin
                    mode_d = wwd_pkg::WWD_RUN;
                end else if (extWake) begin
                    mode_d = wwd_pkg::WWD_RESUME;
                    resume_d = longResumeDelay ? wwd_pkg::RESUME_W'(RESUME_LONG - 1)
                                               : wwd_pkg::RESUME_W'(RESUME_SHORT - 1);
                end
            end
            default: begin
                if (resume_q == '0) begin
                    mode_d = wwd_pkg::WWD_RUN;
                end else begin
                    resume_d = resume_q - 1'b1;
                end
            end
        endcase
        if (decNow) begin
            cnt_d = cnt_q - 1'b1;
            if (active && cnt_q == wwd_pkg::CNT_EXPIRE_FROM) begin
                fire = 1'b1;
            end
        end
        if (ctrlWrite) begin
            cnt_d = ctrlWdata[wwd_pkg::CNT_W-1:0];
            activation_d = activation_q | ctrlWdata[wwd_pkg::ACT_BIT];
            if ((ctrlWdata[wwd_pkg::ACT_BIT] || active) && !ctrlWdata[wwd_pkg::TOP_BIT]) begin
                fire = 1'b1;
            end
        end
        // Woken by reset from halt: delayed start.
        if (!strapDone_q && wokeFromReset) begin
            mode_d = wwd_pkg::WWD_RESUME;
            resume_d = longResumeDelay ? wwd_pkg::RESUME_W'(RESUME_LONG - 1)
                                       : wwd_pkg::RESUME_W'(RESUME_SHORT - 1);
        end
    end

    always_comb begin
        pulse_d = pulse_q;
        if (fire) begin
            pulse_d = wwd_pkg::PULSE_W'(wwd_pkg::PULSE_CYCLES);
        end else if (pulse_q != '0) begin
            pulse_d = pulse_q - 1'b1;
        end
        rdata_d = {activation_d, cnt_d};
        counting_d = (mode_d == wwd_pkg::WWD_RUN);
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            activation_q <= 1'b0;
            cnt_q <= wwd_pkg::CTRL_RESET[wwd_pkg::CNT_W-1:0];
            mode_q <= wwd_pkg::WWD_RUN;
            resume_q <= '0;
            pulse_q <= '0;
            strapDone_q <= 1'b0;
            ctrlRdata <= wwd_pkg::CTRL_RESET;
            counting <= 1'b1;
            resetPin_n <= 1'b1;
            resetPinOe_n <= 1'b1;
        end else begin
            activation_q <= activation_d;
            cnt_q <= cnt_d;
            mode_q <= mode_d;
            resume_q <= resume_d;
            pulse_q <= pulse_d;
            strapDone_q <= strapDone_d;
            ctrlRdata <= rdata_d;
            counting <= counting_d;
            resetPin_n <= 1'b0;
            resetPinOe_n <= !(pulse_d != '0);
        end
    end

    // Assertions.
    // Expiry pulse.
    chk_expire_pulse: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (tick && mode_q != wwd_pkg::WWD_FROZEN && mode_q != wwd_pkg::WWD_RESUME
         && active && cnt_q == wwd_pkg::CNT_EXPIRE_FROM && !ctrlWrite)
        |=> !resetPinOe_n [*8])
        else $error("expiry did not drive reset pin");

    chk_pulse_end: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (pulse_q == wwd_pkg::PULSE_W'(1) && !fire) |=> resetPinOe_n)
        else $error("reset pulse did not end");

    chk_act_sticky: assert property (@(posedge sys_clk) disable iff (!arst_n)
        activation_q |=> activation_q)
        else $error("activation bit cleared");

    chk_idle_no_fire: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (!active && !(ctrlWrite && ctrlWdata[wwd_pkg::ACT_BIT])) |-> !fire)
        else $error("reset raised while inactive");

    chk_soft_reset: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (ctrlWrite && ctrlWdata[7] && !ctrlWdata[6]) |=> !resetPinOe_n)
        else $error("software reset missing");

    chk_halt_reset: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (mode_q == wwd_pkg::WWD_RUN && haltEnter && !timebaseInterruptEnable
         && haltResetOption && active) |=> !resetPinOe_n)
        else $error("halt reset missing");

    chk_halt_no_reset: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (mode_q == wwd_pkg::WWD_RUN && haltEnter && !timebaseInterruptEnable
         && !haltResetOption && strapDone_q) |=> mode_q == wwd_pkg::WWD_HALT_ONE)
        else $error("plain halt did not enter single step");

    chk_halt_once: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (mode_q == wwd_pkg::WWD_HALT_ONE && tick) |=> mode_q == wwd_pkg::WWD_FROZEN)
        else $error("halt did not freeze after one step");

    chk_frozen_hold: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (mode_q == wwd_pkg::WWD_FROZEN && !ctrlWrite) |=> $stable(cnt_q))
        else $error("counter moved while frozen");

    chk_active_halt: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (mode_q == wwd_pkg::WWD_RUN && haltEnter && timebaseInterruptEnable && strapDone_q)
        |=> mode_q == wwd_pkg::WWD_FROZEN)
        else $error("active-halt not entered");

    chk_osc_wake: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (mode_q == wwd_pkg::WWD_FROZEN && timebaseInterruptEnable && oscWake) |=> counting)
        else $error("counting did not restart at once");

    chk_free_run: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (tick && mode_q == wwd_pkg::WWD_RUN && !ctrlWrite) |=> cnt_q == $past(cnt_q) - 7'h01)
        else $error("counter did not decrement");

    chk_write_load: assert property (@(posedge sys_clk) disable iff (!arst_n)
        ctrlWrite |=> cnt_q == $past(ctrlWdata[6:0]))
        else $error("write did not load counter");

    chk_ctrl_layout: assert property (@(posedge sys_clk) disable iff (!arst_n)
        ctrlWrite |=> ctrlRdata[6:0] == $past(ctrlWdata[6:0]) && ctrlRdata[wwd_pkg::ACT_BIT]
        == ($past(activation_q) | $past(ctrlWdata[wwd_pkg::ACT_BIT])))
        else $error("control read value wrong");

    chk_hw_active: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (hardwareWatchdogOption && ctrlWrite && !ctrlWdata[6]) |=> !resetPinOe_n)
        else $error("hardware option not active");

    chk_resume_wait: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (mode_q == wwd_pkg::WWD_RESUME && resume_q != '0) |=> mode_q == wwd_pkg::WWD_RESUME)
        else $error("resumed too early");

    chk_resume_len: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (mode_q == wwd_pkg::WWD_FROZEN && extWake && !timebaseInterruptEnable)
        |=> (mode_q == wwd_pkg::WWD_RESUME) [*3])
        else $error("wake did not hold off counting");

    chk_reset_resume: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (!strapDone_q && wokeFromReset) |-> mode_d == wwd_pkg::WWD_RESUME)
        else $error("reset out of halt did not delay counting");

    // Main scenarios.
    cov_expire: cover property (@(posedge sys_clk) fire && cnt_q == wwd_pkg::CNT_EXPIRE_FROM);
    cov_active_halt: cover property (@(posedge sys_clk) mode_q == wwd_pkg::WWD_FROZEN);
    cov_resume: cover property (@(posedge sys_clk) mode_q == wwd_pkg::WWD_RESUME);
    cov_soft_reset: cover property (@(posedge sys_clk) ctrlWrite && ctrlWdata[7] && !ctrlWdata[6]);
    cov_halt_reset: cover property (@(posedge sys_clk) mode_q == wwd_pkg::WWD_RUN && haltEnter
        && haltResetOption && active);
endmodule : wwd_watchdog
`default_nettype wire

// ===== verification/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin miscompares++; \
    $display("CHECK FAILED %s expected %0h seen %0h", nm, ex, got); end end
module testbench;
    localparam int PS = 16;
    localparam int RS = 4;
    localparam int RL = 8;
    logic sys_clk = 1'b0;
    logic arst_n = 1'b0;
    logic ctrlWrite = 1'b0;
    logic [7:0] ctrlWdata = 8'h00;
    logic haltEnter = 1'b0;
    logic extWake = 1'b0;
    logic oscWake = 1'b0;
    logic wokeFromReset = 1'b0;
    logic tbIe = 1'b0;
    logic haltOpt = 1'b0;
    logic hwOpt = 1'b0;
    logic longDelay = 1'b0;
    logic [7:0] ctrlRdata;
    logic counting;
    logic resetPin_n;
    logic resetPinOe_n;
    logic seenLow;
    logic [7:0] v;
    int miscompares = 0;
    int cmp_count = 0;
    int n;
    int steps[3];
    always #12.5 sys_clk = ~sys_clk;
    wwd_watchdog #(.PRESCALE(PS), .RESUME_SHORT(RS), .RESUME_LONG(RL)) dut (
        .sys_clk(sys_clk), .arst_n(arst_n), .ctrlWrite(ctrlWrite), .ctrlWdata(ctrlWdata),
        .haltEnter(haltEnter), .extWake(extWake), .oscWake(oscWake),
        .wokeFromReset(wokeFromReset), .timebaseInterruptEnable(tbIe),
        .haltResetOption(haltOpt), .hardwareWatchdogOption(hwOpt),
        .longResumeDelay(longDelay), .ctrlRdata(ctrlRdata), .counting(counting),
        .resetPin_n(resetPin_n), .resetPinOe_n(resetPinOe_n));
    task automatic stop_test();
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : stop_test
    function automatic logic in_range(input int got, input int lo, input int hi);
        return (got >= lo) && (got <= hi);
    endfunction : in_range
    // Options are {timebase enable, halt option, hardware option, long delay}.
    task automatic do_reset(input logic woke, input logic [3:0] opts);
        @(posedge sys_clk);
        arst_n <= 1'b0;
        wokeFromReset <= woke;
        {tbIe, haltOpt, hwOpt, longDelay} <= opts;
        repeat (2) @(posedge sys_clk);
        arst_n <= 1'b1;
        @(posedge sys_clk);
        wokeFromReset <= 1'b0;
        #1;
    endtask : do_reset
    task automatic write(input logic [7:0] d);
        @(posedge sys_clk);
        ctrlWrite <= 1'b1;
        ctrlWdata <= d;
        @(posedge sys_clk);
        ctrlWrite <= 1'b0;
        #1;
    endtask : write
    // Pulses haltEnter, extWake or oscWake for one cycle.
    task automatic strobe(input int which);
        @(posedge sys_clk);
        haltEnter <= (which == 0);
        extWake <= (which == 1);
        oscWake <= (which == 2);
        @(posedge sys_clk);
        {haltEnter, extWake, oscWake} <= 3'h0;
        #1;
    endtask : strobe
    // Waits for the reset pulse (sel 0) or for counting (sel 1).
    task automatic wait_for(input int sel, input int lim, output int cnt);
        cnt = 0;
        while (!((sel == 0) ? (resetPinOe_n === 1'b0) : (counting === 1'b1))) begin
            if (cnt >= lim) begin
                miscompares++;
                stop_test();
            end
            @(posedge sys_clk);
            #1;
            cnt++;
        end
    endtask : wait_for
    task automatic run_watch(input int cycles);
        seenLow = 1'b0;
        repeat (cycles) begin
            @(posedge sys_clk);
            #1;
            if (resetPinOe_n !== 1'b1) seenLow = 1'b1;
        end
    endtask : run_watch
    initial begin
        void'($urandom(32'hB06DDE5A));
        do_reset(1'b0, 4'h0);
        `CHK("ctrl reset", 8'h7F, ctrlRdata)
        `CHK("pin idle", 1'b1, resetPinOe_n)
        for (int i = 0; i < 2; i++) begin
            v = ctrlRdata;
            n = 0;
            while (ctrlRdata === v && n < 4 * PS) begin
                @(posedge sys_clk);
                #1;
                n++;
            end
        end
        `CHK("tick spacing", PS, n)
        run_watch(70 * PS);
        `CHK("no reset inactive", 1'b0, seenLow)
        `CHK("counter ran", 1'b0, ctrlRdata[6])
        $display("free run test done");
        do_reset(1'b0, 4'h0);
        write(8'hFF);
        write(8'h7F);
        `CHK("sticky activation", 1'b1, ctrlRdata[7])
        `CHK("no reset top set", 1'b1, resetPinOe_n)
        write({2'b10, 6'($urandom)});
        `CHK("software reset", 1'b0, resetPinOe_n)
        `CHK("pin level", 1'b0, resetPin_n)
        n = 0;
        while (resetPinOe_n === 1'b0 && n < 40) begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        `CHK("pulse length", wwd_pkg::PULSE_CYCLES, n)
        $display("software reset test done");
        do_reset(1'b0, 4'h0);
        for (int i = 0; i < 6; i++) begin
            write(8'hC0 | 8'($urandom_range(63, 2)));
            run_watch(PS);
            `CHK("refresh holds", 1'b0, seenLow)
        end
        steps = '{0, 63, $urandom_range(62, 1)};
        foreach (steps[i]) begin
            do_reset(1'b0, 4'h0);
            write(8'hC0 | 8'(steps[i]));
            wait_for(0, 2000, n);
            `CHK("timeout window", 1'b1, in_range(n, steps[i] * PS, (steps[i] + 1) * PS + 2))
        end
        $display("timeout test done");
        do_reset(1'b0, 4'h4);
        write(8'hFF);
        strobe(0);
        wait_for(0, 2, n);
        `CHK("halt reset", 1'b0, resetPinOe_n)
        do_reset(1'b0, 4'h0);
        write(8'hC1);
        strobe(0);
        run_watch(2 * PS);
        v = ctrlRdata;
        `CHK("halt frozen", 1'b0, counting)
        run_watch(6 * PS);
        `CHK("frozen value", v, ctrlRdata)
        `CHK("frozen no reset", 1'b0, seenLow)
        strobe(1);
        wait_for(1, RS + 3, n);
        `CHK("short resume", 1'b1, in_range(n, RS - 2, RS + 1))
        wait_for(0, 2 * PS, n);
        `CHK("expire after wake", 1'b0, resetPinOe_n)
        $display("halt test done");
        do_reset(1'b0, 4'h8);
        write(8'hC1);
        strobe(0);
        run_watch(4 * PS);
        `CHK("active halt stop", 1'b0, counting)
        `CHK("active halt hold", 8'hC1, ctrlRdata)
        `CHK("active halt quiet", 1'b0, seenLow)
        strobe(2);
        wait_for(1, 2, n);
        `CHK("osc wake", 1'b1, counting)
        do_reset(1'b1, 4'h1);
        `CHK("reset exit ctrl", 8'h7F, ctrlRdata)
        wait_for(1, RL + 3, n);
        `CHK("long resume", 1'b1, in_range(n, RL - 2, RL + 1))
        do_reset(1'b0, 4'h2);
        write(8'h3F);
        `CHK("hardware option", 1'b0, resetPinOe_n)
        $display("mode test done");
        stop_test();
    end
    initial begin
        #2500000;
        miscompares++;
        stop_test();
    end
endmodule : testbench
`default_nettype wire
